// ===== design/ptpti_pkg.sv
// shared widths, field positions and timing figures for the time and latency inputs
package ptpti_pkg;
	localparam int LONG_W      = 96;
	localparam int SHORT_W     = 64;
	localparam int SEC_W       = 48;
	localparam int NS_W        = 32;
	localparam int FNS_W       = 16;
	localparam int SNS_W       = 48;
	localparam int LAT_FAST_W  = 16;
	localparam int LAT_SLOW_W  = 22;
	localparam int LAT_FRAC_W  = 10;
	localparam int FNS_LSB     = 0;
	localparam int NS_LSB      = 16;
	localparam int SEC_LSB     = 48;
	localparam int SNS_LSB     = 16;
	localparam int LAT_CYC_LSB = 10;
	// active clock periods in nanoseconds for the fast and slow link
	localparam int FAST_PERIOD_NS = 3;
	localparam int SLOW_PERIOD_NS = 8;
	localparam logic [31:0] NS_PER_SEC = 32'h3b9aca00;
	localparam logic [95:0] LONG_RESET  = 96'h0;
	localparam logic [63:0] SHORT_RESET = 64'h0;

	typedef struct packed {
		logic [SEC_W-1:0] sec;
		logic [NS_W-1:0]  ns;
		logic [FNS_W-1:0] fns;
	} ptpti_long_t;

	typedef struct packed {
		logic [SNS_W-1:0] ns;
		logic [FNS_W-1:0] fns;
	} ptpti_short_t;
endpackage : ptpti_pkg

// ===== design/ptpti_if.sv
// link between the wall time and line latency source and the mac timestamp side
`timescale 1ns/1ns
interface ptpti_if;
	import ptpti_pkg::*;
	logic [LONG_W-1:0]     egress_wall_time_long_fast;
	logic [LONG_W-1:0]     egress_wall_time_long_slow;
	logic [LONG_W-1:0]     ingress_wall_time_long_fast;
	logic [LONG_W-1:0]     ingress_wall_time_long_slow;
	logic [SHORT_W-1:0]    egress_wall_time_short_fast;
	logic [SHORT_W-1:0]    egress_wall_time_short_slow;
	logic [SHORT_W-1:0]    ingress_wall_time_short_fast;
	logic [SHORT_W-1:0]    ingress_wall_time_short_slow;
	logic [LAT_FAST_W-1:0] egress_line_latency_fast;
	logic [LAT_SLOW_W-1:0] egress_line_latency_slow;
	logic [LAT_FAST_W-1:0] ingress_line_latency_fast;
	logic [LAT_SLOW_W-1:0] ingress_line_latency_slow;

	modport source (
		output egress_wall_time_long_fast, egress_wall_time_long_slow,
		output ingress_wall_time_long_fast, ingress_wall_time_long_slow,
		output egress_wall_time_short_fast, egress_wall_time_short_slow,
		output ingress_wall_time_short_fast, ingress_wall_time_short_slow,
		output egress_line_latency_fast, egress_line_latency_slow,
		output ingress_line_latency_fast, ingress_line_latency_slow
	);
	modport mac (
		input egress_wall_time_long_fast, egress_wall_time_long_slow,
		input ingress_wall_time_long_fast, ingress_wall_time_long_slow,
		input egress_wall_time_short_fast, egress_wall_time_short_slow,
		input ingress_wall_time_short_fast, ingress_wall_time_short_slow,
		input egress_line_latency_fast, egress_line_latency_slow,
		input ingress_line_latency_fast, ingress_line_latency_slow
	);
endinterface : ptpti_if

// ===== design/ptpti_source.sv
// wall time source and line latency reporter driving the link
`timescale 1ns/1ns
module ptpti_source
	import ptpti_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic                  load,
	input  wire logic [LONG_W-1:0]     load_time,
	input  wire logic [LAT_SLOW_W-1:0] egress_latency,
	input  wire logic [LAT_SLOW_W-1:0] ingress_latency,
	ptpti_if.source                    link
);
	typedef struct packed {
		ptpti_long_t               now;
		logic [SHORT_W-1:0]        total;
		logic [LAT_SLOW_W-1:0]     eg_lat;
		logic [LAT_SLOW_W-1:0]     in_lat;
	} ptpti_src_state_t;

	ptpti_src_state_t st;
	ptpti_src_state_t next_st;

	always_comb begin
		next_st = st;
		if (load) begin
			next_st.now = ptpti_long_t'(load_time);
			next_st.total = {16'h0, load_time[SEC_LSB +: SEC_W]} * 64'(NS_PER_SEC)
				+ 64'(load_time[NS_LSB +: NS_W]);
		end else if (st.now.ns + 32'(FAST_PERIOD_NS) >= NS_PER_SEC) begin
			next_st.now.sec = st.now.sec + 48'h1;
			next_st.now.ns = st.now.ns + 32'(FAST_PERIOD_NS) - NS_PER_SEC;
			next_st.total = st.total + 64'(FAST_PERIOD_NS);
		end else begin
			next_st.now.ns = st.now.ns + 32'(FAST_PERIOD_NS);
			next_st.total = st.total + 64'(FAST_PERIOD_NS);
		end
		// latency reports cover medium to the mii boundary of each mode
		next_st.eg_lat = egress_latency;
		next_st.in_lat = ingress_latency;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// both egress and ingress copies come from the one mac clock
	assign link.egress_wall_time_long_fast   = st.now;
	assign link.egress_wall_time_long_slow   = st.now;
	assign link.ingress_wall_time_long_fast  = st.now;
	assign link.ingress_wall_time_long_slow  = st.now;
	assign link.egress_wall_time_short_fast  = {st.total[SNS_W-1:0], st.now.fns};
	assign link.egress_wall_time_short_slow  = {st.total[SNS_W-1:0], st.now.fns};
	assign link.ingress_wall_time_short_fast = {st.total[SNS_W-1:0], st.now.fns};
	assign link.ingress_wall_time_short_slow = {st.total[SNS_W-1:0], st.now.fns};
	assign link.egress_line_latency_fast     = st.eg_lat[LAT_FAST_W-1:0];
	assign link.egress_line_latency_slow     = st.eg_lat;
	assign link.ingress_line_latency_fast    = st.in_lat[LAT_FAST_W-1:0];
	assign link.ingress_line_latency_slow    = st.in_lat;
endmodule : ptpti_source

// ===== design/ptpti_mac.sv
// mac side: picks the speed variant and yields latency corrected timestamps
`timescale 1ns/1ns
module ptpti_mac
	import ptpti_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire logic               fast_mode,
	input  wire logic               egress_capture,
	input  wire logic               ingress_capture,
	ptpti_if.mac                    link,
	output logic [LONG_W-1:0]       egress_stamp_long,
	output logic [SHORT_W-1:0]      egress_stamp_short,
	output logic                    egress_stamp_valid,
	output logic [LONG_W-1:0]       ingress_stamp_long,
	output logic [SHORT_W-1:0]      ingress_stamp_short,
	output logic                    ingress_stamp_valid
);
	typedef struct packed {
		ptpti_long_t  eg_long;
		ptpti_short_t eg_short;
		logic         eg_valid;
		ptpti_long_t  in_long;
		ptpti_short_t in_short;
		logic         in_valid;
	} ptpti_mac_state_t;

	ptpti_mac_state_t st;
	ptpti_mac_state_t next_st;

	// latency in whole cycles and 1/1024 cycle, scaled to ns with 16 fraction bits
	function automatic logic [47:0] ptpti_lat_ns(
		input logic [LAT_SLOW_W-1:0] lat,
		input logic                  fast
	);
		logic [LAT_SLOW_W-LAT_CYC_LSB-1:0] cyc;
		logic [LAT_FRAC_W-1:0]             frac;
		logic [47:0]                       period;
		logic [47:0]                       whole;
		logic [47:0]                       part;
		cyc    = lat[LAT_CYC_LSB +: (LAT_SLOW_W - LAT_CYC_LSB)];
		frac   = lat[0 +: LAT_FRAC_W];
		period = fast ? 48'(FAST_PERIOD_NS) : 48'(SLOW_PERIOD_NS);
		whole  = (48'(cyc) * period) << FNS_W;
		part   = (48'(frac) * period) << (FNS_W - LAT_FRAC_W);
		return whole + part;
	endfunction : ptpti_lat_ns

	// signed add of ns.fraction to a long time, with seconds carry or borrow
	function automatic ptpti_long_t ptpti_long_adj(input ptpti_long_t t,
		input logic [47:0] d, input logic sub);
		logic [63:0] nsf;
		logic [63:0] lim;
		ptpti_long_t r;
		lim = 64'({NS_PER_SEC, 16'h0});
		r = t;
		nsf = sub ? 64'({t.ns, t.fns}) - 64'(d) : 64'({t.ns, t.fns}) + 64'(d);
		if (sub && ({t.ns, t.fns} < 48'(d))) begin
			nsf = nsf + lim;
			r.sec = t.sec - 48'h1;
		end else if (!sub && nsf >= lim) begin
			nsf = nsf - lim;
			r.sec = t.sec + 48'h1;
		end
		r.ns = nsf[NS_LSB +: NS_W];
		r.fns = nsf[FNS_LSB +: FNS_W];
		return r;
	endfunction : ptpti_long_adj

	// speed variant of a long time bus
	function automatic ptpti_long_t ptpti_pick_long(
		input logic              fast,
		input logic [LONG_W-1:0] on_fast,
		input logic [LONG_W-1:0] on_slow
	);
		return ptpti_long_t'(fast ? on_fast : on_slow);
	endfunction : ptpti_pick_long

	// speed variant of a short time bus
	function automatic ptpti_short_t ptpti_pick_short(
		input logic               fast,
		input logic [SHORT_W-1:0] on_fast,
		input logic [SHORT_W-1:0] on_slow
	);
		return ptpti_short_t'(fast ? on_fast : on_slow);
	endfunction : ptpti_pick_short

	// speed variant of a latency bus; the narrow fast form gets zero cycles on top
	function automatic logic [LAT_SLOW_W-1:0] ptpti_pick_lat(
		input logic                  fast,
		input logic [LAT_FAST_W-1:0] on_fast,
		input logic [LAT_SLOW_W-1:0] on_slow
	);
		return fast ? LAT_SLOW_W'(on_fast) : on_slow;
	endfunction : ptpti_pick_lat

	// short form has no seconds, so it simply wraps modulo its width
	function automatic ptpti_short_t ptpti_short_adj(
		input ptpti_short_t t,
		input logic [47:0]  d,
		input logic         sub
	);
		logic [SHORT_W-1:0] sum;
		sum = sub ? SHORT_W'(t) - SHORT_W'(d) : SHORT_W'(t) + SHORT_W'(d);
		return ptpti_short_t'(sum);
	endfunction : ptpti_short_adj

	logic [LONG_W-1:0]     eg_long_sel;
	logic [LONG_W-1:0]     in_long_sel;
	logic [SHORT_W-1:0]    eg_short_sel;
	logic [SHORT_W-1:0]    in_short_sel;
	logic [LAT_SLOW_W-1:0] eg_lat_sel;
	logic [LAT_SLOW_W-1:0] in_lat_sel;
	logic [47:0]           eg_corr;
	logic [47:0]           in_corr;

	always_comb begin
		next_st = st;
		// choose the bus set that matches the link speed
		eg_long_sel  = ptpti_pick_long(fast_mode, link.egress_wall_time_long_fast,
			link.egress_wall_time_long_slow);
		in_long_sel  = ptpti_pick_long(fast_mode, link.ingress_wall_time_long_fast,
			link.ingress_wall_time_long_slow);
		eg_short_sel = ptpti_pick_short(fast_mode, link.egress_wall_time_short_fast,
			link.egress_wall_time_short_slow);
		in_short_sel = ptpti_pick_short(fast_mode, link.ingress_wall_time_short_fast,
			link.ingress_wall_time_short_slow);
		eg_lat_sel   = ptpti_pick_lat(fast_mode, link.egress_line_latency_fast,
			link.egress_line_latency_slow);
		in_lat_sel   = ptpti_pick_lat(fast_mode, link.ingress_line_latency_fast,
			link.ingress_line_latency_slow);
		eg_corr = ptpti_lat_ns(eg_lat_sel, fast_mode);
		in_corr = ptpti_lat_ns(in_lat_sel, fast_mode);
		next_st.eg_valid = egress_capture;
		next_st.in_valid = ingress_capture;
		if (egress_capture) begin
			next_st.eg_long = ptpti_long_adj(ptpti_long_t'(eg_long_sel), eg_corr, 1'b0);
			next_st.eg_short = ptpti_short_adj(ptpti_short_t'(eg_short_sel), eg_corr, 1'b0);
		end
		if (ingress_capture) begin
			next_st.in_long = ptpti_long_adj(ptpti_long_t'(in_long_sel), in_corr, 1'b1);
			next_st.in_short = ptpti_short_adj(ptpti_short_t'(in_short_sel), in_corr, 1'b1);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign egress_stamp_long   = st.eg_long;
	assign egress_stamp_short  = st.eg_short;
	assign egress_stamp_valid  = st.eg_valid;
	assign ingress_stamp_long  = st.in_long;
	assign ingress_stamp_short = st.in_short;
	assign ingress_stamp_valid = st.in_valid;
endmodule : ptpti_mac

// ===== dv/ptpti_props.sv
// concurrent checks on the wall time and line latency link
`timescale 1ns/1ns
module ptpti_props
	import ptpti_pkg::*;
(
	input wire logic                  sys_clk,
	input wire logic                  reset,
	input wire logic [LONG_W-1:0]     egress_wall_time_long_fast,
	input wire logic [LONG_W-1:0]     egress_wall_time_long_slow,
	input wire logic [LONG_W-1:0]     ingress_wall_time_long_fast,
	input wire logic [SHORT_W-1:0]    egress_wall_time_short_fast,
	input wire logic [LAT_FAST_W-1:0] egress_line_latency_fast,
	input wire logic [LAT_SLOW_W-1:0] egress_line_latency_slow,
	input wire logic [LAT_FAST_W-1:0] ingress_line_latency_fast,
	input wire logic [LAT_SLOW_W-1:0] ingress_line_latency_slow
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// whole nanoseconds that the short form must carry
	wire logic [SNS_W-1:0] total_ns = egress_wall_time_long_fast[95:48] * 48'(NS_PER_SEC)
		+ 48'(egress_wall_time_long_fast[47:16]);
	long_pair_a: assert property (egress_wall_time_long_fast == egress_wall_time_long_slow)
		else $error("long fast and slow buses differ");
	ns_range_a: assert property (egress_wall_time_long_fast[47:16] < NS_PER_SEC)
		else $error("egress nanoseconds out of range");
	in_range_a: assert property (ingress_wall_time_long_fast[47:16] < NS_PER_SEC)
		else $error("ingress nanoseconds out of range");
	short_ns_a: assert property (egress_wall_time_short_fast[63:16] == total_ns)
		else $error("short nanoseconds do not match long time");
	short_fns_a: assert property (
		egress_wall_time_short_fast[15:0] == egress_wall_time_long_fast[15:0])
		else $error("short fraction does not match long time");
	eg_lat_a: assert property (egress_line_latency_fast == egress_line_latency_slow[15:0])
		else $error("egress fast latency differs");
	in_lat_a: assert property (ingress_line_latency_fast == ingress_line_latency_slow[15:0])
		else $error("ingress fast latency differs");
	rst_zero_a: assert property ($fell(reset) |-> egress_wall_time_long_fast == '0)
		else $error("time bus not cleared by reset");
endmodule : ptpti_props

// ===== dv/ptpti_tb.sv
// self-checking bench joining the time source to the mac side
`timescale 1ns/1ns
module ptpti_tb;
	import ptpti_pkg::*;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
	$display("FAIL %0t mismatch %h expected %h", $time, a, e); end end
	logic                  sys_clk, reset, load, fast_mode, egress_capture, ingress_capture;
	logic [LONG_W-1:0]     load_time, egress_stamp_long, ingress_stamp_long;
	logic [SHORT_W-1:0]    egress_stamp_short, ingress_stamp_short;
	logic                  egress_stamp_valid, ingress_stamp_valid;
	logic [LAT_SLOW_W-1:0] egress_latency, ingress_latency;
	int                    miscompares = 0, n_compared = 0, cycles = 0;
	ptpti_if link();
	ptpti_source i_ptpti_source(.sys_clk(sys_clk), .reset(reset), .load(load),
		.load_time(load_time), .egress_latency(egress_latency),
		.ingress_latency(ingress_latency), .link(link));
	ptpti_mac i_ptpti_mac(.sys_clk(sys_clk), .reset(reset), .fast_mode(fast_mode),
		.egress_capture(egress_capture), .ingress_capture(ingress_capture), .link(link),
		.egress_stamp_long(egress_stamp_long), .egress_stamp_short(egress_stamp_short),
		.egress_stamp_valid(egress_stamp_valid), .ingress_stamp_long(ingress_stamp_long),
		.ingress_stamp_short(ingress_stamp_short), .ingress_stamp_valid(ingress_stamp_valid));
	ptpti_props i_ptpti_props(.sys_clk(sys_clk), .reset(reset),
		.egress_wall_time_long_fast(link.egress_wall_time_long_fast),
		.egress_wall_time_long_slow(link.egress_wall_time_long_slow),
		.ingress_wall_time_long_fast(link.ingress_wall_time_long_fast),
		.egress_wall_time_short_fast(link.egress_wall_time_short_fast),
		.egress_line_latency_fast(link.egress_line_latency_fast),
		.egress_line_latency_slow(link.egress_line_latency_slow),
		.ingress_line_latency_fast(link.ingress_line_latency_fast),
		.ingress_line_latency_slow(link.ingress_line_latency_slow));
	// corrected {long, short} stamp; latency scaled to 1/65536 ns units
	function automatic logic [159:0] fix(logic [95:0] t, logic [21:0] lat, logic fast, logic sub);
		logic [127:0] tot;
		logic [127:0] nsall;
		logic [127:0] corr;
		corr = 128'(fast ? lat[15:0] : lat) * 128'(fast ? FAST_PERIOD_NS : SLOW_PERIOD_NS) * 64;
		tot = (128'(t[95:48]) * NS_PER_SEC + 128'(t[47:16])) * 128'h10000 + 128'(t[15:0]);
		tot = sub ? tot - corr : tot + corr;
		nsall = tot >> 16;
		return {48'(nsall / NS_PER_SEC), 32'(nsall % NS_PER_SEC), tot[15:0], nsall[47:0], tot[15:0]};
	endfunction : fix
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic pulse_load(logic [95:0] t);
		@(negedge sys_clk);
		load = 1'b1;
		load_time = t;
		@(negedge sys_clk);
		load = 1'b0;
	endtask : pulse_load
	task automatic stamp_both(logic [95:0] t, logic fast);
		logic [159:0] eg_exp;
		logic [159:0] in_exp;
		eg_exp = fix(t, egress_latency, fast, 1'b0);
		in_exp = fix(t, ingress_latency, fast, 1'b1);
		fast_mode = fast;
		pulse_load(t);
		egress_capture = 1'b1;
		ingress_capture = 1'b1;
		@(negedge sys_clk);
		egress_capture = 1'b0;
		ingress_capture = 1'b0;
		`CHK({egress_stamp_valid, ingress_stamp_valid}, 2'b11)
		`CHK({egress_stamp_long, egress_stamp_short}, eg_exp)
		`CHK({ingress_stamp_long, ingress_stamp_short}, in_exp)
		@(negedge sys_clk);
		`CHK({egress_stamp_valid, ingress_stamp_valid}, 2'b00)
	endtask : stamp_both
	task automatic back_to_back(logic [95:0] t);
		logic [159:0] exp0;
		logic [159:0] exp1;
		exp0 = fix(t, egress_latency, 1'b0, 1'b0);
		// second capture sees the time one source tick later
		exp1 = fix(t + (96'(FAST_PERIOD_NS) << NS_LSB), egress_latency, 1'b0, 1'b0);
		fast_mode = 1'b0;
		pulse_load(t);
		egress_capture = 1'b1;
		@(negedge sys_clk);
		`CHK({egress_stamp_valid, egress_stamp_long}, {1'b1, exp0[159:64]})
		@(negedge sys_clk);
		egress_capture = 1'b0;
		`CHK({egress_stamp_valid, egress_stamp_long}, {1'b1, exp1[159:64]})
	endtask : back_to_back
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 500) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		{reset, load, fast_mode, egress_capture, ingress_capture} = 5'h10;
		load_time = '0;
		egress_latency = 22'h3abcd;
		ingress_latency = 22'h2f123;
		repeat (4) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		stamp_both({48'h5, 32'h3b9ac9fe, 16'hfff0}, 1'b0);
		stamp_both({48'h5, 32'h3b9ac9fe, 16'hfff0}, 1'b1);
		stamp_both({48'h7, 32'h1, 16'h2}, 1'b0);
		stamp_both({48'h7, 32'h1, 16'h2}, 1'b1);
		back_to_back({48'h7, 32'h1, 16'h2});
		close_out();
	end
endmodule : ptpti_tb
